// [nbm_busy_timer.sv]
`timescale 1ns/1ns
`default_nettype none
// Down counter that holds busy for a loaded number of cycles
module nbm_busy_timer #(
	parameter int W = 16
) (
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic start,
	input wire logic [W-1:0] load,
	output logic busy,
	output logic done
);
	logic [W-1:0] count; // Cycles still to run
	logic [W-1:0] next_count;
	logic next_busy;
	logic next_done;

	generate
		if (W < 2) begin : g_chk
			$error("nbm_busy_timer: W must be at least 2");
		end
	endgenerate

	// Next count; a new start restarts the count
	always_comb begin
		next_count = count;
		next_busy = busy;
		next_done = 1'b0;
		if (start) begin
			next_count = load;
			next_busy = 1'b1;
		end else if (busy) begin
			if (count <= {{(W-1){1'b0}}, 1'b1}) begin
				next_busy = 1'b0;
				next_done = 1'b1; // One-cycle end pulse
			end else begin
				next_count = count - {{(W-1){1'b0}}, 1'b1};
			end
		end
	end

	// Timer registers
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			count <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			count <= next_count;
			busy <= next_busy;
			done <= next_done;
		end
	end
endmodule
`default_nettype wire

// [nbm_core_properties.sv]
`timescale 1ns/1ns
`default_nettype none
// Port checks on the flash core
module nbm_core_properties (
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic CMD_VALID,
	input wire nbm_pkg::nbm_op_t CMD_OP,
	input wire logic READY,
	input wire logic RD_VALID,
	input wire logic [7:0] STATUS
);
	import nbm_pkg::*;
	logic acc; // Command taken while ready
	logic rcmd; // Reset command strobe
	assign acc = CMD_VALID && READY;
	assign rcmd = CMD_VALID && CMD_OP == NBM_OP_RESET;
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RSTN);
	a_read_span: assert property (acc && CMD_OP == NBM_OP_READ |-> ##1 !READY ##250 (READY && RD_VALID))
		else $error("read busy span wrong");
	a_reset_span: assert property (rcmd && READY |-> ##1 !READY ##50 (READY && STATUS == 8'hC0))
		else $error("reset busy span wrong");
	a_fail_moment: assert property ($changed(STATUS[0]) |-> $rose(READY) || $past(rcmd))
		else $error("fail bit moved off completion");
	a_status_bits: assert property (STATUS[7:6] == {1'b1, READY} && STATUS[5:1] == 5'h00)
		else $error("status bits wrong");
	a_valid_pulse: assert property (RD_VALID |-> $rose(READY) ##1 !RD_VALID)
		else $error("read valid not one pulse");
	a_busy_hold: assert property ($fell(READY) |-> (!READY) [*8])
		else $error("busy too short");
	// Main scenarios reached
	c_read: cover property (acc && CMD_OP == NBM_OP_READ);
	c_fail: cover property ($rose(STATUS[0]));
	c_reset: cover property (rcmd);
endmodule
bind nbm_flash_core nbm_core_properties u_prop (.CLOCK(CLOCK), .RSTN(RSTN), .CMD_VALID(CMD_VALID),
	.CMD_OP(CMD_OP), .READY(READY), .RD_VALID(RD_VALID), .STATUS(STATUS));
`default_nettype wire

// [nbm_defines.svh]
`ifndef NBM_DEFINES_SVH
`define NBM_DEFINES_SVH

// Clock period in ns (10 MHz)
`define NBM_CLK_NS 100
// Cell-to-register transfer, longest time in us
`define NBM_T_R_US 25
`define NBM_T_R_CYC ((`NBM_T_R_US * 1000) / `NBM_CLK_NS)
// Reset from ready, longest time in us
`define NBM_T_RST_US 5
`define NBM_T_RST_CYC ((`NBM_T_RST_US * 1000) / `NBM_CLK_NS)
// Reset during an erase, longest time in us
`define NBM_T_RST_BUSY_US 500
`define NBM_T_RST_BUSY_CYC ((`NBM_T_RST_BUSY_US * 1000) / `NBM_CLK_NS)
// Typical page program time in us
`define NBM_T_PROG_US 200
`define NBM_T_PROG_CYC ((`NBM_T_PROG_US * 1000) / `NBM_CLK_NS)
// Typical block erase time in us
`define NBM_T_BERS_US 2000
`define NBM_T_BERS_CYC ((`NBM_T_BERS_US * 1000) / `NBM_CLK_NS)

// Status byte field positions
`define NBM_ST_FAIL 0
`define NBM_ST_RDY 6
`define NBM_ST_WPN 7

// Erased byte value and factory bad marker value
`define NBM_ERASED 8'hFF
`define NBM_BAD_MARK 8'h00

`endif

// [nbm_flash_core.sv]
`include "nbm_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module nbm_flash_core #(
	parameter int NBLK = 1024,
	parameter int NPG = 64,
	parameter logic [NBLK-1:0] FACTORY_BAD = '0,
	parameter int T_PROG_CYC = `NBM_T_PROG_CYC,
	parameter int T_BERS_CYC = `NBM_T_BERS_CYC,
	parameter int T_RST_BUSY_CYC = `NBM_T_RST_BUSY_CYC,
	localparam int BW = $clog2(NBLK),
	localparam int PW = $clog2(NPG)
) (
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic CMD_VALID,
	input wire nbm_pkg::nbm_op_t CMD_OP,
	input wire logic [BW-1:0] CMD_BLOCK,
	input wire logic [PW-1:0] CMD_PAGE,
	input wire logic [7:0] CMD_DATA,
	input wire logic [7:0] CMD_SPARE,
	input wire logic WEAR_VALID,
	input wire logic [BW-1:0] WEAR_BLOCK,
	output logic READY,
	output logic RD_VALID,
	output logic [7:0] RD_DATA,
	output logic [7:0] RD_SPARE,
	output logic [7:0] STATUS
);
	import nbm_pkg::*;

	localparam int TW = 16; // Timer width
	localparam int NIDX = NBLK * NPG; // Stored pages
	// Loads one short: the timer end pulse costs one more registered cycle
	localparam logic [TW-1:0] LD_R = TW'(`NBM_T_R_CYC - 1);
	localparam logic [TW-1:0] LD_RST = TW'(`NBM_T_RST_CYC - 1);
	localparam logic [TW-1:0] LD_RSTB = TW'(T_RST_BUSY_CYC - 1);
	localparam logic [TW-1:0] LD_PROG = TW'(T_PROG_CYC - 1);
	localparam logic [TW-1:0] LD_BERS = TW'(T_BERS_CYC - 1);

	generate
		if (NBLK < 2 || NPG < 2 || (1 << BW) != NBLK || (1 << PW) != NPG) begin : g_chk_geo
			$error("nbm_flash_core: NBLK and NPG must be powers of two, at least 2");
		end
		if (T_PROG_CYC < 2 || T_BERS_CYC < 2 || T_RST_BUSY_CYC < 2) begin : g_chk_t
			$error("nbm_flash_core: busy times must be at least two cycles");
		end
		if (T_PROG_CYC >= 2**TW || T_BERS_CYC >= 2**TW || T_RST_BUSY_CYC >= 2**TW) begin : g_chk_w
			$error("nbm_flash_core: busy time exceeds timer width");
		end
	endgenerate

	logic [7:0] main_mem [NIDX]; // First main byte of each page
	logic [7:0] spare_mem [NIDX]; // First spare byte of each page
	logic [NBLK-1:0] worn; // Blocks that fail program and erase

	nbm_state_t state; // Core state
	nbm_state_t next_state;
	nbm_op_t op; // Operation in flight
	nbm_op_t next_op;
	logic [BW-1:0] blk; // Target block
	logic [BW-1:0] next_blk;
	logic [PW-1:0] pg; // Target page
	logic [PW-1:0] next_pg;
	logic [7:0] dat; // Data to program
	logic [7:0] next_dat;
	logic [7:0] spr; // Spare to program
	logic [7:0] next_spr;
	logic fail; // Last program or erase failed
	logic next_fail;
	logic next_ready;
	logic next_rd_valid;
	logic [7:0] next_rd_data;
	logic [7:0] next_rd_spare;
	logic [7:0] next_status;

	logic tmr_start; // Load the busy timer
	logic [TW-1:0] tmr_load; // Busy length in cycles
	logic tmr_busy; // Timer running
	logic tmr_done; // Timer expired this cycle
	logic pg_we; // Commit a program
	logic blk_ers; // Commit an erase
	logic [BW+PW-1:0] idx; // Page index of target

	assign idx = {blk, pg};

	// Single busy timer shared by read, program, erase and reset
	nbm_busy_timer #(
		.W(TW)
	) u_timer (
		.CLOCK(CLOCK),
		.RSTN(RSTN),
		.start(tmr_start),
		.load(tmr_load),
		.busy(tmr_busy),
		.done(tmr_done)
	);

	// Command acceptance and completion
	always_comb begin
		next_state = state;
		next_op = op;
		next_blk = blk;
		next_pg = pg;
		next_dat = dat;
		next_spr = spr;
		next_fail = fail;
		next_ready = READY;
		next_rd_valid = 1'b0;
		next_rd_data = RD_DATA;
		next_rd_spare = RD_SPARE;
		tmr_start = 1'b0;
		tmr_load = LD_R;
		pg_we = 1'b0;
		blk_ers = 1'b0;
		if (CMD_VALID && CMD_OP == NBM_OP_RESET) begin
			// Reset aborts any operation in flight
			tmr_start = 1'b1;
			tmr_load = (state == NBM_S_BUSY && op == NBM_OP_ERASE) ? LD_RSTB : LD_RST;
			next_op = NBM_OP_RESET;
			next_fail = 1'b0;
			next_state = NBM_S_BUSY;
			next_ready = 1'b0;
		end else begin
			case (state)
				NBM_S_READY: begin
					if (CMD_VALID) begin
						next_blk = CMD_BLOCK;
						next_pg = CMD_PAGE;
						next_dat = CMD_DATA;
						next_spr = CMD_SPARE;
						case (CMD_OP)
							NBM_OP_READ: begin
								tmr_start = 1'b1;
								tmr_load = LD_R;
							end
							NBM_OP_PROG: begin
								tmr_start = 1'b1;
								tmr_load = LD_PROG;
							end
							NBM_OP_ERASE: begin
								tmr_start = 1'b1;
								tmr_load = LD_BERS;
							end
							default: begin
								// Status read needs no busy time
								tmr_start = 1'b0;
							end
						endcase
						if (tmr_start) begin
							next_op = CMD_OP;
							next_state = NBM_S_BUSY;
							next_ready = 1'b0;
						end
					end
				end
				NBM_S_BUSY: begin
					// Only reset and status are heard while busy
					if (tmr_done) begin
						next_state = NBM_S_READY;
						next_ready = 1'b1;
						case (op)
							NBM_OP_READ: begin
								next_rd_data = main_mem[idx];
								next_rd_spare = spare_mem[idx];
								next_rd_valid = 1'b1;
							end
							NBM_OP_PROG: begin
								next_fail = worn[blk];
								pg_we = ~worn[blk];
							end
							NBM_OP_ERASE: begin
								next_fail = worn[blk];
								blk_ers = ~worn[blk];
							end
							default: begin
								// Reset completion only returns to ready
								next_fail = 1'b0;
							end
						endcase
					end
				end
				default: begin
					next_state = NBM_S_READY;
					next_ready = 1'b1;
				end
			endcase
		end
		// Status byte: ready, not protected, pass or fail
		next_status = 8'h00;
		next_status[`NBM_ST_RDY] = next_ready;
		next_status[`NBM_ST_WPN] = 1'b1;
		next_status[`NBM_ST_FAIL] = next_fail;
	end

	// Control registers
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			state <= NBM_S_READY;
			op <= NBM_OP_STATUS;
			blk <= '0;
			pg <= '0;
			dat <= 8'hFF;
			spr <= 8'hFF;
			fail <= 1'b0;
			READY <= 1'b1;
			RD_VALID <= 1'b0;
			RD_DATA <= 8'h00;
			RD_SPARE <= 8'h00;
			STATUS <= 8'hC0;
		end else begin
			state <= next_state;
			op <= next_op;
			blk <= next_blk;
			pg <= next_pg;
			dat <= next_dat;
			spr <= next_spr;
			fail <= next_fail;
			READY <= next_ready;
			RD_VALID <= next_rd_valid;
			RD_DATA <= next_rd_data;
			RD_SPARE <= next_rd_spare;
			STATUS <= next_status;
		end
	end

	// Wear flags; factory bad blocks also refuse program and erase
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			worn <= FACTORY_BAD;
		end else if (WEAR_VALID) begin
			worn[WEAR_BLOCK] <= 1'b1;
		end
	end

	// Cell array; program only clears bits, erase sets a whole block
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			for (int i = 0; i < NIDX; i++) begin
				main_mem[i] <= `NBM_ERASED;
				spare_mem[i] <= (FACTORY_BAD[i / NPG] && (i % NPG) < 2) ?
					`NBM_BAD_MARK : `NBM_ERASED;
			end
		end else if (pg_we) begin
			main_mem[idx] <= main_mem[idx] & dat;
			spare_mem[idx] <= spare_mem[idx] & spr;
		end else if (blk_ers) begin
			for (int p = 0; p < NPG; p++) begin
				main_mem[{blk, PW'(p)}] <= `NBM_ERASED;
				spare_mem[{blk, PW'(p)}] <= `NBM_ERASED;
			end
		end
	end
endmodule
`default_nettype wire

// [nbm_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
// Host side: issues commands, keeps bad and retired tables
module nbm_host_model (
	input wire logic clock,
	input wire logic ready,
	input wire logic [7:0] rd_data,
	input wire logic [7:0] rd_spare,
	output nbm_pkg::nbm_op_t op,
	output logic cmd_valid,
	output logic [2:0] blk,
	output logic [1:0] pg,
	output logic [7:0] dat,
	output logic [7:0] spr
);
	import nbm_pkg::*;
	logic [7:0] bad = 8'h00; // Factory bad table
	logic [7:0] dead = 8'h00; // Retired blocks
	int busy = 0; // Cycles of last busy span
	// Check-bit column of each data bit, all distinct and not one-hot
	localparam logic [3:0] ECC_COL [8] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC};
	// Check bits of a byte
	function automatic logic [3:0] ecc_code(input logic [7:0] v);
		logic [3:0] c;
		c = 4'h0;
		for (int i = 0; i < 8; i++) if (v[i]) c ^= ECC_COL[i];
		return c;
	endfunction
	// Flip the one data bit whose column matches the syndrome
	function automatic logic [7:0] ecc_fix(input logic [7:0] v, input logic [3:0] c);
		logic [3:0] syn;
		logic [7:0] f;
		syn = ecc_code(v) ^ c;
		f = v;
		for (int i = 0; i < 8; i++) if (syn == ECC_COL[i]) f[i] = ~f[i];
		return f;
	endfunction
	initial begin
		cmd_valid = 1'b0;
		op = NBM_OP_STATUS;
		{blk, pg, dat, spr} = '0;
	end
	// One command, only once ready, then wait for ready
	task automatic issue(input nbm_op_t o, input int b, input int p, input logic [7:0] d,
		input logic [7:0] s);
		if (o != NBM_OP_READ && dead[b]) return;
		@(negedge clock);
		while (ready !== 1'b1) @(negedge clock);
		@(posedge clock);
		cmd_valid <= 1'b1;
		op <= o;
		{blk, pg, dat, spr} <= {b[2:0], p[1:0], d, s};
		@(posedge clock);
		cmd_valid <= 1'b0;
		busy = 0;
		@(negedge clock);
		while (ready !== 1'b1 && busy < 30000) begin
			busy++;
			@(negedge clock);
		end
	endtask
	// Move pages below n to a fresh block, then the held page n
	task automatic replace(input int a, input int n, input logic [7:0] d, input logic [7:0] s,
		output int b);
		b = a;
		for (int i = 7; i >= 0; i--) if (!bad[i] && !dead[i] && i != a) b = i;
		for (int p = 0; p < n; p++) begin
			issue(NBM_OP_READ, a, p, 8'hFF, 8'hFF);
			issue(NBM_OP_PROG, b, p, rd_data, rd_spare);
		end
		issue(NBM_OP_PROG, b, n, d, s);
		dead[a] = 1'b1;
	endtask
endmodule
`default_nettype wire

// [nbm_pkg.sv]
package nbm_pkg;
	// Operations accepted on the command port
	typedef enum logic [2:0] {
		NBM_OP_READ,
		NBM_OP_PROG,
		NBM_OP_ERASE,
		NBM_OP_RESET,
		NBM_OP_STATUS
	} nbm_op_t;
	// Core sequencing states
	typedef enum logic {
		NBM_S_READY,
		NBM_S_BUSY
	} nbm_state_t;
endpackage

// [tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
// Host model drives the core, a byte model predicts results
module tb_top;
	import nbm_pkg::*;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic wear_valid = 1'b0;
	logic [2:0] wear_block = 3'h0;
	logic [7:0] worn = 8'h02; // Factory bad block is worn too
	nbm_op_t op;
	logic cmd_valid, ready, rd_valid;
	logic [2:0] blk;
	logic [1:0] pg;
	logic [7:0] dat, spr, rd_data, rd_spare, status, d, s;
	logic [7:0] m_dat [32]; // Expected main bytes
	logic [7:0] m_spr [32]; // Expected spare bytes
	int seed = 32'h4131;
	int n_mismatch = 0;
	int cmp_count = 0;
	int nb;
	nbm_flash_core #(.NBLK(8), .NPG(4), .FACTORY_BAD(8'h02), .T_PROG_CYC(20),
		.T_BERS_CYC(30)) dut (.CLOCK(clock), .RSTN(rstn), .CMD_VALID(cmd_valid), .CMD_OP(op),
		.CMD_BLOCK(blk), .CMD_PAGE(pg), .CMD_DATA(dat), .CMD_SPARE(spr), .WEAR_VALID(wear_valid),
		.WEAR_BLOCK(wear_block), .READY(ready), .RD_VALID(rd_valid), .RD_DATA(rd_data),
		.RD_SPARE(rd_spare), .STATUS(status));
	nbm_host_model host (.clock(clock), .ready(ready), .rd_data(rd_data), .rd_spare(rd_spare),
		.op(op), .cmd_valid(cmd_valid), .blk(blk), .pg(pg), .dat(dat), .spr(spr));
	initial begin
		forever #50 clock = ~clock;
	end
	task automatic summarize();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Page read against the byte model
	task automatic rd(input int b, input int p);
		host.issue(NBM_OP_READ, b, p, 8'h00, 8'h00);
		check("rd_valid", 8'h01, {7'h00, rd_valid});
		check("busy_read", 8'hFA, host.busy[7:0]);
		check("rd_data", m_dat[b*4+p], rd_data);
		check("rd_spare", m_spr[b*4+p], rd_spare);
	endtask
	// Program, fail bit follows wear
	task automatic pr(input int b, input int p);
		d = 8'($random(seed));
		s = 8'($random(seed));
		host.issue(NBM_OP_PROG, b, p, d, s);
		check("prog_status", 8'hC0 | {7'h00, worn[b]}, status);
		if (!worn[b]) begin
			m_dat[b*4+p] &= d;
			m_spr[b*4+p] &= s;
		end
	endtask
	task automatic er(input int b);
		host.issue(NBM_OP_ERASE, b, 0, 8'hFF, 8'hFF);
		check("erase_status", 8'hC0 | {7'h00, worn[b]}, status);
		for (int p = 0; p < 4 && !worn[b]; p++) {m_dat[b*4+p], m_spr[b*4+p]} = 16'hFFFF;
	endtask
	task automatic wear(input int b);
		@(posedge clock);
		wear_valid <= 1'b1;
		wear_block <= b[2:0];
		@(posedge clock);
		wear_valid <= 1'b0;
		worn[b] = 1'b1;
	endtask
	// Watchdog
	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		summarize();
	end
	// Main sequence
	initial begin
		for (int i = 0; i < 32; i++) {m_dat[i], m_spr[i]} = (i == 4 || i == 5) ? 16'hFF00 : 16'hFFFF;
		repeat (4) @(posedge clock);
		check("status_reset", 8'hC0, status);
		rstn <= 1'b1;
		for (int b = 0; b < 8; b++) begin
			rd(b, 0);
			host.bad[b] = rd_spare !== 8'hFF;
		end
		check("bad_table", 8'h02, host.bad);
		host.issue(NBM_OP_RESET, 0, 0, 8'h00, 8'h00);
		check("busy_reset", 8'h32, host.busy[7:0]);
		host.issue(NBM_OP_STATUS, 0, 0, 8'h00, 8'h00);
		check("busy_status", 8'h00, host.busy[7:0]);
		check("status_idle", 8'hC0, status);
		for (int p = 0; p < 3; p++) pr(0, p);
		wear(0);
		pr(0, 3);
		for (int p = 0; p < 4; p++) rd(0, p);
		host.replace(0, 3, d, s, nb);
		check("spare_block", 8'h02, nb[7:0]);
		host.issue(NBM_OP_ERASE, 0, 0, 8'hFF, 8'hFF);
		check("retired_erase", 8'hC0, status);
		for (int p = 0; p < 3; p++) {m_dat[nb*4+p], m_spr[nb*4+p]} = {m_dat[p], m_spr[p]};
		{m_dat[nb*4+3], m_spr[nb*4+3]} = {d, s};
		for (int p = 0; p < 4; p++) rd(nb, p);
		for (int i = 0; i < 8; i++) begin
			d = rd_data ^ (8'h01 << i);
			check("ecc_fix", m_dat[nb*4+3], host.ecc_fix(d, host.ecc_code(m_dat[nb*4+3])));
		end
		er(nb);
		rd(nb, 1);
		wear(4);
		er(4);
		summarize();
	end
endmodule
`default_nettype wire
